/* epdo_cfg_if.sv */
/*
  latched configuration shared by the top and its epdo_zpulse sub-module.
  assumes one clock domain.
*/
`timescale 1ns/100ps
interface epdo_cfg_if;
  logic [2:0]        polarity;
  logic [15:0]       zwidth;
  epdo_pkg::epdo_src_t src;
  logic              cmp_en;
  modport ctrl (output polarity, output zwidth, output src, output cmp_en);
  modport user (input polarity, input zwidth, input src, input cmp_en);
endinterface

/* epdo_defs.svh */
/*
  register offsets, field positions, reset values and timing counts of the divided
  encoder pulse output block. assumes a 20 MHz system clock.
*/
`ifndef EPDO_DEFS_SVH
`define EPDO_DEFS_SVH
`define EPDO_OFS_MON_SEL     16'h2540
`define EPDO_OFS_POLARITY    16'h2542
`define EPDO_OFS_ZWIDTH      16'h2543
`define EPDO_OFS_SRC_SEL     16'h2544
`define EPDO_OFS_OVS_LIMIT   16'h2545
`define EPDO_OFS_FAN_LEVEL   16'h2546
`define EPDO_OFS_CMP_EN      16'h2570
`define EPDO_OFS_CMP_MODE    16'h2571
`define EPDO_OFS_STATUS      16'h2580
`define EPDO_OFS_RESTART     16'h2581
`define EPDO_OFS_SPEED       16'h2582
`define EPDO_POL_Z_BIT       0
`define EPDO_POL_A_BIT       1
`define EPDO_POL_B_BIT       2
`define EPDO_MON_SEL_RST     20'h3C00C
`define EPDO_MON_SEL_MAX     20'hFFFFF
`define EPDO_ZWIDTH_MAX      16'h01F4
`define EPDO_SRC_MAX         16'h0004
`define EPDO_CLK_HZ          20000000
`define EPDO_US_NS           1000
`define EPDO_CLK_NS          50
`define EPDO_CYC_PER_US      ((`EPDO_US_NS + `EPDO_CLK_NS - 1) / `EPDO_CLK_NS)
`define EPDO_SPEED_WIN_MS    1
`define EPDO_SPEED_WIN_CYC   (`EPDO_CLK_HZ / 1000 * `EPDO_SPEED_WIN_MS)
`endif

/* epdo_host_model.sv */
/*
  host side receiver of the divided pulses: quadrature position count and
  width of the last high index pulse in clock cycles.
  assumes outputs of the drive are registered levels on the same clock.
*/
`timescale 1ns/100ps
module epdo_host_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // divided pulses
  input  wire logic i_a,
  input  wire logic i_b,
  input  wire logic i_z,
  // decoded results
  output int        o_pos,
  output int        o_zw
);
  logic [1:0] ab_q;
  int         z_cnt;

  // gray phase of {a,b}: 00, 10, 11, 01 counts up
  function automatic logic [1:0] ph(input logic [1:0] v);
    ph = {v[0], v[1] ^ v[0]};
  endfunction

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ab_q  <= 2'h0;
      o_pos <= 0;
      z_cnt <= 0;
      o_zw  <= 0;
    end else begin
      ab_q <= {i_a, i_b};
      case (2'(ph({i_a, i_b}) - ph(ab_q)))
        2'h1: o_pos <= o_pos + 1;
        2'h3: o_pos <= o_pos - 1;
        default: ;
      endcase
      if (i_z) begin
        z_cnt <= z_cnt + 1;
      end else if (z_cnt != 0) begin
        o_zw  <= z_cnt;
        z_cnt <= 0;
      end
    end
  end
endmodule

/* epdo_pkg.sv */
/*
  types of the divided encoder pulse output block.
  assumes epdo_defs.svh supplies the numeric constants.
*/
package epdo_pkg;
  typedef enum logic [2:0] {
    EPDO_SRC_MOTOR = 3'h0,
    EPDO_SRC_EXT   = 3'h1,
    EPDO_SRC_RSVD  = 3'h2,
    EPDO_SRC_PULSE = 3'h3,
    EPDO_SRC_OFF   = 3'h4
  } epdo_src_t;
  typedef enum logic [1:0] {
    EPDO_Z_IDLE  = 2'h0,
    EPDO_Z_CYCLE = 2'h1,
    EPDO_Z_EXTRA = 2'h2
  } epdo_zst_t;
endpackage

/* epdo_speed.sv */
/*
  external encoder speed meter and overspeed flag.
  assumes i_step is one pulse per count of the external encoder, same clock.
*/
`timescale 1ns/100ps
`include "epdo_defs.svh"
module epdo_speed #(
  parameter int WIN_CYC    = `EPDO_SPEED_WIN_CYC,
  parameter int COUNTS_REV = 4000
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // encoder counts and limit
  input  wire logic        i_step,
  input  wire logic [15:0] i_limit_rpm,
  // results
  output logic [31:0]      o_rpm,
  output logic             o_over
);
  localparam int SCALE = 60 * 1000 / COUNTS_REV;
  logic [31:0] win_ff, nxt_win;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [31:0] rpm_ff, nxt_rpm;
  logic        over_ff, nxt_over;

  always_comb begin
    nxt_win = win_ff + 32'h1;
    nxt_cnt = i_step ? cnt_ff + 32'h1 : cnt_ff;
    nxt_rpm = rpm_ff;
    if (win_ff == 32'(WIN_CYC - 1)) begin
      nxt_win = 32'h0;
      nxt_cnt = {31'h0, i_step};
      nxt_rpm = 32'(cnt_ff * 32'(SCALE));
    end
    nxt_over = (rpm_ff > {16'h0000, i_limit_rpm}); // R8
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      win_ff  <= 32'h0;
      cnt_ff  <= 32'h0;
      rpm_ff  <= 32'h0;
      over_ff <= 1'b0;
    end else begin
      win_ff  <= nxt_win;
      cnt_ff  <= nxt_cnt;
      rpm_ff  <= nxt_rpm;
      over_ff <= nxt_over;
    end
  end

  assign o_rpm  = rpm_ff;
  assign o_over = over_ff;

  property p_over_flag;
    @(posedge i_clk) disable iff (!i_reset_n)
    (rpm_ff > {16'h0000, i_limit_rpm}) |=> over_ff;
  endproperty
  a_over_flag: assert property (p_over_flag) // R8
    else $error("overspeed not flagged");
  c_over: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(over_ff));
endmodule

/* epdo_top.sv */
/*
  divided encoder pulse output: register file, source select, quadrature
  generation, polarity and index stretching.
  assumes pulse sources are pins; the register port master never waits.
*/
// Overview of operation
// [R1] monitor select holds index in upper digits, sub-index in lowest, up to FFFFF
// [R2] polarity bit 0 inverts Z, in divider and comparison use
// [R3] polarity bit 1 inverts A only when A is the comparison output
// [R4] polarity bit 2 inverts B only when B is the comparison output
// [R5] Z width zero gives a Z pulse of one A/B period
// [R6] Z width 1..500 adds that many microseconds to the A/B period
// [R7] source: motor, external, reserved, pulse pass-through without comparison, off
// [R8] external encoder speed above a threshold raises an overspeed flag
// [R9] polarity, Z width and source take effect only after a restart
// [R10] A/B quadrature follows source position steps, Z marks the source index
`timescale 1ns/100ps
`include "epdo_defs.svh"
module epdo_top #(
  parameter int CYC_PER_US = `EPDO_CYC_PER_US,
  parameter int WIN_CYC    = `EPDO_SPEED_WIN_CYC,
  parameter int COUNTS_REV = 4000
) (
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RESET_N,
  // register port
  input  wire logic [15:0] I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  // motor encoder pins
  input  wire logic        I_MOT_A,
  input  wire logic        I_MOT_B,
  input  wire logic        I_MOT_Z,
  // external encoder pins
  input  wire logic        I_EXT_A,
  input  wire logic        I_EXT_B,
  input  wire logic        I_EXT_Z,
  // pulse command pins
  input  wire logic        I_CMD_A,
  input  wire logic        I_CMD_B,
  // comparison pulses from the comparator
  input  wire logic        I_CMP_A,
  input  wire logic        I_CMP_B,
  // divided outputs and external overspeed flag
  output logic             O_DIV_A,
  output logic             O_DIV_B,
  output logic             O_DIV_Z,
  output logic             O_EXT_OVERSPEED
);
  epdo_cfg_if cfg ();

  // registers
  logic [19:0] mon_sel_ff, nxt_mon_sel;
  logic [2:0]  pol_ff, nxt_pol;
  logic [15:0] zw_ff, nxt_zw;
  logic [2:0]  src_ff, nxt_src;
  logic [15:0] ovs_ff, nxt_ovs;
  logic [15:0] fan_ff, nxt_fan;
  logic        cen_ff, nxt_cen;
  logic [1:0]  cmode_ff, nxt_cmode;
  logic [2:0]  apol_ff, nxt_apol;
  logic [15:0] azw_ff, nxt_azw;
  epdo_pkg::epdo_src_t asrc_ff, nxt_asrc;
  logic        pend_ff, nxt_pend;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] rpm;
  logic        over;

  // three-stage pin synchronisers
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_ff, s2_ff, s3_ff;
  logic [NPIN-1:0] pin_ff, nxt_pin;
  assign pin_raw = {I_CMP_B, I_CMP_A, I_CMD_B, I_CMD_A, I_EXT_Z, I_EXT_B, I_EXT_A,
                    I_MOT_Z, I_MOT_B, I_MOT_A};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_comb begin
        nxt_pin[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : pin_ff[gi];
      end
      always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          s1_ff[gi]  <= 1'b0;
          s2_ff[gi]  <= 1'b0;
          s3_ff[gi]  <= 1'b0;
          pin_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi]  <= pin_raw[gi];
          s2_ff[gi]  <= s1_ff[gi];
          s3_ff[gi]  <= s2_ff[gi];
          pin_ff[gi] <= nxt_pin[gi];
        end
      end
    end
  endgenerate

  // register file
  always_comb begin
    nxt_mon_sel = mon_sel_ff;
    nxt_pol     = pol_ff;
    nxt_zw      = zw_ff;
    nxt_src     = src_ff;
    nxt_ovs     = ovs_ff;
    nxt_fan     = fan_ff;
    nxt_cen     = cen_ff;
    nxt_cmode   = cmode_ff;
    nxt_apol    = apol_ff;
    nxt_azw     = azw_ff;
    nxt_asrc    = asrc_ff;
    nxt_pend    = pend_ff;
    nxt_rdata   = 32'h0;
    if (I_WR) begin
      unique case (I_ADDR)
        `EPDO_OFS_MON_SEL: begin
          nxt_mon_sel = I_WDATA[19:0]; // R1
        end
        `EPDO_OFS_POLARITY: begin
          nxt_pol  = I_WDATA[2:0];
          nxt_pend = 1'b1;
        end
        `EPDO_OFS_ZWIDTH: begin
          nxt_zw   = (I_WDATA[15:0] > `EPDO_ZWIDTH_MAX) ? `EPDO_ZWIDTH_MAX : I_WDATA[15:0];
          nxt_pend = 1'b1;
        end
        `EPDO_OFS_SRC_SEL: begin
          if (I_WDATA[15:0] <= `EPDO_SRC_MAX) begin
            nxt_src  = I_WDATA[2:0];
            nxt_pend = 1'b1;
          end
        end
        `EPDO_OFS_OVS_LIMIT: nxt_ovs = I_WDATA[15:0];
        `EPDO_OFS_FAN_LEVEL: nxt_fan = I_WDATA[15:0];
        `EPDO_OFS_CMP_EN: nxt_cen = I_WDATA[0];
        `EPDO_OFS_CMP_MODE: nxt_cmode = I_WDATA[1:0];
        `EPDO_OFS_RESTART: begin
          if (I_WDATA[0]) begin
            nxt_apol = pol_ff; // R9
            nxt_azw  = zw_ff;
            nxt_asrc = epdo_pkg::epdo_src_t'(src_ff);
            nxt_pend = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (I_RD) begin
      unique case (I_ADDR)
        `EPDO_OFS_MON_SEL: nxt_rdata = {12'h000, mon_sel_ff};
        `EPDO_OFS_POLARITY: nxt_rdata = {29'h0, pol_ff};
        `EPDO_OFS_ZWIDTH: nxt_rdata = {16'h0000, zw_ff};
        `EPDO_OFS_SRC_SEL: nxt_rdata = {29'h0, src_ff};
        `EPDO_OFS_OVS_LIMIT: nxt_rdata = {16'h0000, ovs_ff};
        `EPDO_OFS_FAN_LEVEL: nxt_rdata = {16'h0000, fan_ff};
        `EPDO_OFS_CMP_EN: nxt_rdata = {31'h0, cen_ff};
        `EPDO_OFS_CMP_MODE: nxt_rdata = {30'h0, cmode_ff};
        `EPDO_OFS_STATUS: nxt_rdata = {28'h0, pend_ff, asrc_ff == epdo_pkg::EPDO_SRC_OFF,
                                       over, cfg.cmp_en};
        `EPDO_OFS_SPEED: nxt_rdata = rpm;
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mon_sel_ff <= `EPDO_MON_SEL_RST;
      pol_ff     <= 3'h0;
      zw_ff      <= 16'h0000;
      src_ff     <= 3'h0;
      ovs_ff     <= 16'h0000;
      fan_ff     <= 16'h0000;
      cen_ff     <= 1'b0;
      cmode_ff   <= 2'h0;
      apol_ff    <= 3'h0;
      azw_ff     <= 16'h0000;
      asrc_ff    <= epdo_pkg::EPDO_SRC_MOTOR;
      pend_ff    <= 1'b0;
      rdata_ff   <= 32'h0;
    end else begin
      mon_sel_ff <= nxt_mon_sel;
      pol_ff     <= nxt_pol;
      zw_ff      <= nxt_zw;
      src_ff     <= nxt_src;
      ovs_ff     <= nxt_ovs;
      fan_ff     <= nxt_fan;
      cen_ff     <= nxt_cen;
      cmode_ff   <= nxt_cmode;
      apol_ff    <= nxt_apol;
      azw_ff     <= nxt_azw;
      asrc_ff    <= nxt_asrc;
      pend_ff    <= nxt_pend;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign O_RDATA       = rdata_ff;
  assign cfg.polarity  = apol_ff;
  assign cfg.zwidth    = azw_ff;
  assign cfg.src       = asrc_ff;
  assign cfg.cmp_en    = cen_ff && (asrc_ff != epdo_pkg::EPDO_SRC_PULSE); // R7

  // source select and quadrature regeneration
  logic [1:0] ab_ff, nxt_ab;
  logic       prv_z_ff, nxt_prv_z;
  logic       sa, sb, sz, sel_on;
  logic       index_ev, cycle_ev, ext_step;
  logic       z_pulse;
  logic       oa_ff, nxt_oa, ob_ff, nxt_ob, oz_ff, nxt_oz;
  logic       ext_prv_ff, nxt_ext_prv;

  always_comb begin
    sa     = 1'b0;
    sb     = 1'b0;
    sz     = 1'b0;
    sel_on = 1'b1;
    unique case (asrc_ff) // R7
      epdo_pkg::EPDO_SRC_MOTOR: {sz, sb, sa} = pin_ff[2:0];
      epdo_pkg::EPDO_SRC_EXT: {sz, sb, sa} = pin_ff[5:3];
      epdo_pkg::EPDO_SRC_PULSE: {sb, sa} = pin_ff[7:6];
      default: sel_on = 1'b0;
    endcase
    nxt_ab    = sel_on ? {sb, sa} : ab_ff; // R10
    nxt_prv_z = sz;
    index_ev  = sz && !prv_z_ff; // R10
    // forward cycle ends when b falls with a low: {b,a} 10 -> 00
    cycle_ev  = (ab_ff == 2'b10) && (nxt_ab == 2'b00); // R5
    nxt_ext_prv = pin_ff[3];
    ext_step  = pin_ff[3] != ext_prv_ff;
    if (cfg.cmp_en) begin
      nxt_oa = pin_ff[8] ^ apol_ff[`EPDO_POL_A_BIT]; // R3
      nxt_ob = pin_ff[9] ^ apol_ff[`EPDO_POL_B_BIT]; // R4
    end else begin
      nxt_oa = sel_on & ab_ff[0];
      nxt_ob = sel_on & ab_ff[1];
    end
    nxt_oz = sel_on ? (z_pulse ^ apol_ff[`EPDO_POL_Z_BIT]) : 1'b0; // R2
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ab_ff      <= 2'b00;
      prv_z_ff   <= 1'b0;
      ext_prv_ff <= 1'b0;
      oa_ff      <= 1'b0;
      ob_ff      <= 1'b0;
      oz_ff      <= 1'b0;
    end else begin
      ab_ff      <= nxt_ab;
      prv_z_ff   <= nxt_prv_z;
      ext_prv_ff <= nxt_ext_prv;
      oa_ff      <= nxt_oa;
      ob_ff      <= nxt_ob;
      oz_ff      <= nxt_oz;
    end
  end

  assign O_DIV_A = oa_ff;
  assign O_DIV_B = ob_ff;
  assign O_DIV_Z = oz_ff;
  assign O_EXT_OVERSPEED = over;

  epdo_zpulse #(.CYC_PER_US(CYC_PER_US)) u_zpulse (
    .i_clk      (I_SYS_CLK),
    .i_reset_n  (I_RESET_N),
    .i_index    (index_ev),
    .i_ab_cycle (cycle_ev),
    .cfg        (cfg),
    .o_z        (z_pulse)
  );

  epdo_speed #(.WIN_CYC(WIN_CYC), .COUNTS_REV(COUNTS_REV)) u_speed (
    .i_clk       (I_SYS_CLK),
    .i_reset_n   (I_RESET_N),
    .i_step      (ext_step),
    .i_limit_rpm (ovs_ff),
    .o_rpm       (rpm),
    .o_over      (over)
  );

  property p_mon_sel_wr;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (I_WR && I_ADDR == `EPDO_OFS_MON_SEL) |=> mon_sel_ff == $past(I_WDATA[19:0]);
  endproperty
  a_mon_sel_wr: assert property (p_mon_sel_wr) else $error("monitor select not stored"); // R1
  property p_pol_z;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    sel_on |=> oz_ff == ($past(z_pulse) ^ $past(apol_ff[0]));
  endproperty
  a_pol_z: assert property (p_pol_z) else $error("z polarity wrong"); // R2
  property p_pol_a;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    cfg.cmp_en |=> oa_ff == ($past(pin_ff[8]) ^ $past(apol_ff[1]));
  endproperty
  a_pol_a: assert property (p_pol_a) else $error("a comparison polarity wrong"); // R3
  property p_pol_b;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !cfg.cmp_en |=> ob_ff == ($past(sel_on) & $past(ab_ff[1]));
  endproperty
  a_pol_b: assert property (p_pol_b) else $error("b polarity applied outside comparison"); // R4
  property p_src_off;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (asrc_ff == epdo_pkg::EPDO_SRC_OFF && !cen_ff) [*2] |-> !oa_ff && !ob_ff && !oz_ff;
  endproperty
  a_src_off: assert property (p_src_off) else $error("output active while disabled"); // R7
  property p_pulse_nocmp;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    asrc_ff == epdo_pkg::EPDO_SRC_PULSE |-> !cfg.cmp_en;
  endproperty
  a_pulse_nocmp: assert property (p_pulse_nocmp) else $error("comparison in pass-through"); // R7
  property p_restart_only;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !(I_WR && I_ADDR == `EPDO_OFS_RESTART) |=> $stable(asrc_ff) && $stable(apol_ff);
  endproperty
  a_restart_only: assert property (p_restart_only) else $error("config changed early"); // R9
  property p_quad_follow;
    @(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    (sel_on && !cfg.cmp_en) ##1 !cfg.cmp_en |-> oa_ff == $past(ab_ff[0]);
  endproperty
  a_quad_follow: assert property (p_quad_follow) else $error("a does not follow source"); // R10
  c_restart: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) $fell(pend_ff));
  c_index: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) index_ev);
  c_cmp: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N) $rose(cfg.cmp_en));
endmodule

/* epdo_zpulse.sv */
/*
  index pulse stretcher: one a/b period plus an optional width in microseconds.
  assumes i_index and i_ab_cycle are single-cycle pulses on the same clock.
*/
`timescale 1ns/100ps
`include "epdo_defs.svh"
module epdo_zpulse #(
  parameter int CYC_PER_US = `EPDO_CYC_PER_US
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // events
  input  wire logic i_index,
  input  wire logic i_ab_cycle,
  // configuration
  epdo_cfg_if.user  cfg,
  // index pulse
  output logic      o_z
);
  epdo_pkg::epdo_zst_t st_ff, nxt_st;
  logic [15:0] us_ff, nxt_us;
  logic [7:0]  cyc_ff, nxt_cyc;
  logic        z_ff, nxt_z;

  always_comb begin
    nxt_st  = st_ff;
    nxt_us  = us_ff;
    nxt_cyc = cyc_ff;
    unique case (st_ff)
      epdo_pkg::EPDO_Z_IDLE: begin
        if (i_index) begin
          nxt_st = epdo_pkg::EPDO_Z_CYCLE;
        end
      end
      epdo_pkg::EPDO_Z_CYCLE: begin
        if (i_ab_cycle) begin
          if (cfg.zwidth == 16'h0000) begin
            nxt_st = epdo_pkg::EPDO_Z_IDLE; // R5
          end else begin
            nxt_st  = epdo_pkg::EPDO_Z_EXTRA; // R6
            nxt_us  = cfg.zwidth;
            nxt_cyc = 8'(CYC_PER_US - 1);
          end
        end
      end
      epdo_pkg::EPDO_Z_EXTRA: begin
        if (cyc_ff != 8'h00) begin
          nxt_cyc = cyc_ff - 8'h01;
        end else if (us_ff == 16'h0001) begin
          nxt_st = epdo_pkg::EPDO_Z_IDLE;
        end else begin
          nxt_us  = us_ff - 16'h0001; // R6
          nxt_cyc = 8'(CYC_PER_US - 1);
        end
      end
      default: nxt_st = epdo_pkg::EPDO_Z_IDLE;
    endcase
    nxt_z = (nxt_st != epdo_pkg::EPDO_Z_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_ff  <= epdo_pkg::EPDO_Z_IDLE;
      us_ff  <= 16'h0000;
      cyc_ff <= 8'h00;
      z_ff   <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      us_ff  <= nxt_us;
      cyc_ff <= nxt_cyc;
      z_ff   <= nxt_z;
    end
  end

  assign o_z = z_ff;

  property p_z_rise_on_index;
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_ff == epdo_pkg::EPDO_Z_IDLE && i_index) |=> z_ff;
  endproperty
  a_z_rise_on_index: assert property (p_z_rise_on_index) // R10
    else $error("z did not rise on index");
  property p_z_zero_width;
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_ff == epdo_pkg::EPDO_Z_CYCLE && i_ab_cycle && cfg.zwidth == 16'h0000) |=> !z_ff;
  endproperty
  a_z_zero_width: assert property (p_z_zero_width) // R5
    else $error("z not ended after one a/b period");
  // the stretch loads the full width and one microsecond of cycles
  property p_z_stretch;
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_ff == epdo_pkg::EPDO_Z_CYCLE && i_ab_cycle && cfg.zwidth != 16'h0000)
    |=> z_ff && us_ff == $past(cfg.zwidth) && cyc_ff == 8'(CYC_PER_US - 1);
  endproperty
  a_z_stretch: assert property (p_z_stretch) // R6
    else $error("z stretch not started");
  property p_z_stretch_end;
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_ff == epdo_pkg::EPDO_Z_EXTRA && cyc_ff == 8'h00 && us_ff == 16'h0001) |=> !z_ff;
  endproperty
  a_z_stretch_end: assert property (p_z_stretch_end) // R6
    else $error("z stretch did not end");
  c_z_extra: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    st_ff == epdo_pkg::EPDO_Z_EXTRA ##1 st_ff == epdo_pkg::EPDO_Z_IDLE);
endmodule

/* tb_encoder_pulse_divider_output.sv */
/*
  self-checking bench of the divided encoder pulse output block.
  assumes shortened counts: 2 cycles per microsecond, 100-cycle speed window.
*/
`timescale 1ns/100ps
`include "epdo_defs.svh"
module tb_encoder_pulse_divider_output;
  localparam int CPU = 2;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  enc [3] = '{2'h0, 2'h0, 2'h0};
  logic        mot_z = 1'b0;
  logic        ext_z = 1'b0;
  logic        cmp_a = 1'b0;
  logic        cmp_b = 1'b0;
  logic        div_a;
  logic        div_b;
  logic        div_z;
  logic        ovs;
  int          hm_pos;
  int          hm_zw;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [31:0] w0_arr [2] = '{32'h4, 32'h2};

  epdo_top #(.CYC_PER_US(CPU), .WIN_CYC(100), .COUNTS_REV(4000)) i_epdo_top (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata),
    .I_MOT_A(enc[0][1]), .I_MOT_B(enc[0][0]), .I_MOT_Z(mot_z),
    .I_EXT_A(enc[1][1]), .I_EXT_B(enc[1][0]), .I_EXT_Z(ext_z),
    .I_CMD_A(enc[2][1]), .I_CMD_B(enc[2][0]), .I_CMP_A(cmp_a), .I_CMP_B(cmp_b),
    .O_DIV_A(div_a), .O_DIV_B(div_b), .O_DIV_Z(div_z), .O_EXT_OVERSPEED(ovs));

  epdo_host_model i_epdo_host_model (
    .i_clk(clk), .i_reset_n(rst_n), .i_a(div_a), .i_b(div_b), .i_z(div_z),
    .o_pos(hm_pos), .o_zw(hm_zw));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic restart();
    wr(`EPDO_OFS_RESTART, 32'h1);
    repeat (2) @(posedge clk);
  endtask

  // one quadrature step of source s, dir 1 forward, 3 backward
  task automatic step(input int s, input logic [1:0] dir);
    logic [1:0] i;
    i = {enc[s][0], enc[s][1] ^ enc[s][0]} + dir;
    @(posedge clk);
    enc[s] <= {i[1] ^ i[0], i[1]};
    repeat (7) @(posedge clk);
  endtask

  // expected divided a/b for a pin pattern: comparison pins come out inverted
  function automatic logic [1:0] exp_ab(input int mode, input logic [1:0] r);
    exp_ab = (mode == 2) ? ~r : r;
  endfunction

  // index raised at phase 0, so four forward steps end one full a/b cycle
  task automatic zrun(output int w);
    while (enc[0] != 2'h0) step(0, 2'h1);
    @(posedge clk);
    mot_z <= 1'b1;
    repeat (4) step(0, 2'h1);
    mot_z <= 1'b0;
    repeat (1100) @(posedge clk);
    w = hm_zw;
  endtask

  // random pin levels, then compare outputs against expected function of pins
  task automatic pins(input int mode);
    logic [1:0] r;
    repeat (8) begin
      r = 2'($urandom);
      @(posedge clk);
      if (mode == 0) enc[0] <= r;
      else if (mode == 1) enc[2] <= r;
      else {cmp_a, cmp_b} <= r;
      repeat (10) @(posedge clk);
      chk({div_a, div_b}, exp_ab(mode, r));
    end
  endtask

  initial begin
    logic [31:0] v;
    int          p0;
    int          w0;
    int          w1;
    void'($urandom(32'hf0382274));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`EPDO_OFS_MON_SEL, 32'h3C00C);
    rchk(`EPDO_OFS_POLARITY, 32'h0);
    rchk(`EPDO_OFS_ZWIDTH, 32'h0);
    rchk(`EPDO_OFS_SRC_SEL, 32'h0);
    rchk(`EPDO_OFS_OVS_LIMIT, 32'h0);
    rchk(`EPDO_OFS_FAN_LEVEL, 32'h0);
    rchk(`EPDO_OFS_CMP_EN, 32'h0);
    rchk(`EPDO_OFS_CMP_MODE, 32'h0);
    wr(16'h1234, 32'hFFFF);
    rchk(16'h1234, 32'h0);
    v = {12'h0, 20'($urandom)};
    wr(`EPDO_OFS_MON_SEL, v);
    rchk(`EPDO_OFS_MON_SEL, v);
    wr(`EPDO_OFS_MON_SEL, 32'h60921);
    rchk(`EPDO_OFS_MON_SEL, 32'h60921);
    wr(`EPDO_OFS_MON_SEL, 32'hFFFFF);
    rchk(`EPDO_OFS_MON_SEL, 32'hFFFFF);
    // quadrature follows steps of the motor encoder both ways
    repeat (12) step(0, 2'h1);
    repeat (5) step(0, 2'h3);
    repeat (10) @(posedge clk);
    chk(hm_pos, 7);
    // index width: plain A/B cycle, then clamped extra microseconds
    zrun(w0);
    chk(w0 >= 24, 1);
    wr(`EPDO_OFS_ZWIDTH, 32'd600);
    rchk(`EPDO_OFS_ZWIDTH, 32'd500);
    restart();
    zrun(w1);
    chk(w1 - w0, 500 * CPU);
    wr(`EPDO_OFS_ZWIDTH, 32'h0);
    // polarity held back until restart
    wr(`EPDO_OFS_POLARITY, 32'h1);
    repeat (10) @(posedge clk);
    chk(div_z, 0);
    rchk(`EPDO_OFS_STATUS, 32'h8);
    restart();
    repeat (10) @(posedge clk);
    chk(div_z, 1);
    // disabled and reserved sources keep all outputs low
    foreach (w0_arr[k]) begin
      wr(`EPDO_OFS_SRC_SEL, w0_arr[k]);
      restart();
      rchk(`EPDO_OFS_STATUS, (w0_arr[k] == 32'h4) ? 32'h4 : 32'h0);
      p0 = hm_pos;
      repeat (3) step(0, 2'h1);
      repeat (10) @(posedge clk);
      chk({div_a, div_b, div_z}, 0);
      chk(hm_pos, p0);
    end
    wr(`EPDO_OFS_SRC_SEL, 32'h5);
    rchk(`EPDO_OFS_SRC_SEL, 32'h2);
    // pass-through of the command pins, comparison off despite enable
    wr(`EPDO_OFS_POLARITY, 32'h6);
    wr(`EPDO_OFS_CMP_EN, 32'h1);
    wr(`EPDO_OFS_SRC_SEL, 32'h3);
    restart();
    pins(1);
    rchk(`EPDO_OFS_STATUS, 32'h0);
    // comparison pulses inverted by bits 1 and 2
    wr(`EPDO_OFS_SRC_SEL, 32'h0);
    restart();
    rchk(`EPDO_OFS_STATUS, 32'h1);
    pins(2);
    // bits 1 and 2 ignored outside comparison
    wr(`EPDO_OFS_CMP_EN, 32'h0);
    repeat (2) @(posedge clk);
    pins(0);
    // external encoder at about 6 A toggles per window, near 90 rpm
    wr(`EPDO_OFS_OVS_LIMIT, 32'd20);
    repeat (40) step(1, 2'h1);
    chk(ovs, 1);
    wr(`EPDO_OFS_OVS_LIMIT, 32'd10000);
    repeat (40) step(1, 2'h1);
    chk(ovs, 0);
    conclude();
  end
endmodule
